// >>> core/bsc_dev.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Code 0xF selects one-bit bypass register
// [R2] Bypass capture loads zero
// [R3] Bypass cell shifts TDI to TDO
// [R4] Reset instruction shifts reset register
// [R5] Disable bit one blocks port; zero plus fuse enables
// [R6] Disable bit changes on two equal writes
// [R7] Software leaves disable bit alone during debug
// [R8] Scan reset sets status flag bit 4
// [R9] Flag cleared by power-on or written zero
// [R10] Pin: pull-up cell plus two-stage pin cell
// [R11] Raw pin captured; output follows port, direction
// [R12] Pull-up enable needs no global disable, input, port set
// [R13] Alternate functions outside cell; real level captured
// [R14] Analog pins bypass cells; cells at digital edge
// [R15] Reset pin: two observe-only cells
// [R16] Oscillator enable general cell, clock observe-only
// [R17] Internal RC oscillator never scanned
// [R18] Controller enables one main clock at most
// [R19] Code 0xC: unlatched reset while cell holds one
// [R20] Missed second write keeps old value
module bsc_dev #(
   parameter int NPIN = bsc_pkg::BSC_NPIN_DEF,
   parameter int NOSC = bsc_pkg::BSC_NOSC_DEF
) (
   // Clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_nrst,
   // Scan link
   bsc_link_if.dev                  link,
   // Register port
   input  wire logic [7:0]          i_addr,
   input  wire logic [7:0]          i_wdata,
   input  wire logic                i_we,
   input  wire logic                i_re,
   output logic      [7:0]          o_rdata,
   // Strap and power-on event
   input  wire logic                i_scan_port_fuse,
   input  wire logic                i_por,
   // Port pins
   input  wire logic [NPIN-1:0]     i_port_output_bit,
   input  wire logic [NPIN-1:0]     i_pin_direction_bit,
   input  wire logic [NPIN-1:0]     i_pin_level,
   // Reset pin observation
   input  wire logic                i_normal_reset_n,
   input  wire logic                i_high_voltage_reset,
   // Oscillators with external pins
   input  wire logic [NOSC-1:0]     i_osc_enable,
   input  wire logic [NOSC-1:0]     i_osc_clock,
   // Control outputs
   output logic                     o_scan_port_disable,
   output logic                     o_global_pullup_disable,
   output logic                     o_vector_table_select,
   output logic                     o_vector_change_enable,
   output logic                     o_scan_port_enabled,
   output logic                     o_scan_reset,
   output logic                     o_scan_reset_flag,
   output logic [NPIN*bsc_pkg::BSC_PIN_CELLS+2+2*NOSC-1:0] o_chain_latch
);

   // ***************************************************************
   // Chain layout, cell 0 sits next to TDO
   // ***************************************************************
   localparam int CELLS  = bsc_pkg::BSC_PIN_CELLS;
   localparam int B_RST  = NPIN * CELLS;
   localparam int B_OSC  = B_RST + 2;
   localparam int CH     = B_OSC + 2 * NOSC;
   localparam int SYW    = bsc_pkg::BSC_SY_W;
   localparam logic [2:0] WIN_LAST = 3'(bsc_pkg::BSC_WIN_CYC - 1);

   typedef struct packed {
      logic [SYW-1:0] sy1;
      logic [SYW-1:0] sy2;
      logic           tck_d;
      logic           byp;
      logic           rst;
      logic [CH-1:0]  bsr;
      logic [CH-1:0]  lat;
      logic           tdo;
      logic [7:0]     ctrl;
      logic           pend;
      logic           pend_val;
      logic [2:0]     win;
      logic [7:0]     stat;
      logic [7:0]     rdata;
      logic           en;
   } bsc_dev_state_type;

   bsc_dev_state_type st_r;
   bsc_dev_state_type st_nxt;

   logic [SYW-1:0] sy_in;
   logic [CH-1:0]  cap_val;
   logic           tck_rise;
   logic           tck_fall;
   logic           enabled;
   logic [3:0]     ir;
   logic           sel_byp;
   logic           sel_rst;
   logic           sel_bsr;

   // ***************************************************************
   // Link sampling
   // ***************************************************************
   // Fuse is a strap from outside, so it rides the same synchroniser
   assign sy_in = {i_scan_port_fuse, link.instr, link.update_dr, link.shift_dr,
                   link.capture_dr, link.tdi, link.tck};

   // Edges and decode use only the second stage
   assign tck_rise = st_r.sy2[bsc_pkg::BSC_SY_TCK] & ~st_r.tck_d;
   assign tck_fall = ~st_r.sy2[bsc_pkg::BSC_SY_TCK] & st_r.tck_d;
   assign enabled  = st_r.en;                                               // [R5]
   assign ir       = st_r.sy2[bsc_pkg::BSC_SY_IR +: 4];

   // Instruction decode; unknown codes fall back to bypass
   assign sel_rst = (ir == bsc_pkg::BSC_IR_RESET);                          // [R19]
   assign sel_bsr = (ir == bsc_pkg::BSC_IR_SAMPLE);
   assign sel_byp = ~sel_rst & ~sel_bsr;                                    // [R1]

   // ***************************************************************
   // Capture values of the boundary chain
   // ***************************************************************
   // Pin level is taken raw; a synchroniser would hide what the pin shows.
   // Alternate and analog functions attach beyond these cells.   // [R13] [R14]
   always_comb begin
      cap_val = '0;
      for (int i = 0; i < NPIN; i++) begin
         cap_val[i*CELLS]   = ~st_r.ctrl[bsc_pkg::BSC_CTRL_PUD]
                              & ~i_pin_direction_bit[i]
                              & i_port_output_bit[i];                       // [R10] [R12]
         cap_val[i*CELLS+1] = i_pin_direction_bit[i];                       // [R11]
         cap_val[i*CELLS+2] = i_pin_level[i];                               // [R11]
      end
      cap_val[B_RST]   = i_normal_reset_n;                                  // [R15]
      cap_val[B_RST+1] = i_high_voltage_reset;                              // [R15]
      // Only pinned oscillators have cells; the RC one has none   // [R17]
      for (int k = 0; k < NOSC; k++) begin
         cap_val[B_OSC+2*k]   = i_osc_enable[k];                            // [R16]
         cap_val[B_OSC+2*k+1] = i_osc_clock[k];                             // [R16]
      end
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      st_nxt       = st_r;
      st_nxt.sy1   = sy_in;
      st_nxt.sy2   = st_r.sy1;
      st_nxt.tck_d = st_r.sy2[bsc_pkg::BSC_SY_TCK];

      // Scan data registers on the sampled scan clock
      if (enabled && tck_rise) begin
         if (st_r.sy2[bsc_pkg::BSC_SY_CAP]) begin
            if (sel_byp) begin
               st_nxt.byp = 1'b0;                                           // [R2]
            end
            if (sel_bsr) begin
               st_nxt.bsr = cap_val;
            end
         end else if (st_r.sy2[bsc_pkg::BSC_SY_SH]) begin
            if (sel_byp) begin
               st_nxt.byp = st_r.sy2[bsc_pkg::BSC_SY_TDI];                  // [R3]
            end
            if (sel_rst) begin
               st_nxt.rst = st_r.sy2[bsc_pkg::BSC_SY_TDI];                  // [R4]
            end
            if (sel_bsr) begin
               // Three cells per pin: pull-up cell, control cell, then data cell   // [R10]
               st_nxt.bsr = {st_r.sy2[bsc_pkg::BSC_SY_TDI], st_r.bsr[CH-1:1]};
            end
         end else if (st_r.sy2[bsc_pkg::BSC_SY_UPD] && sel_bsr) begin
            // Preload latches only; they are not wired to the pins
            st_nxt.lat = st_r.bsr;
         end
      end

      // TDO moves on the falling edge so the far end samples it stable
      if (!enabled) begin
         st_nxt.tdo = 1'b0;
      end else if (tck_fall) begin
         st_nxt.tdo = sel_rst ? st_r.rst : (sel_bsr ? st_r.bsr[0] : st_r.byp);
      end

      // Timed window for the disable bit
      if (st_r.pend) begin
         st_nxt.win = st_r.win + 3'h1;
         if (st_r.win == WIN_LAST) begin
            st_nxt.pend = 1'b0;                                             // [R20]
         end
      end

      // Register writes
      if (i_we && i_addr == bsc_pkg::BSC_OFS_CTRL) begin
         st_nxt.ctrl = (st_r.ctrl & ~bsc_pkg::BSC_CTRL_PLAIN)
                       | (i_wdata & bsc_pkg::BSC_CTRL_PLAIN);
         if (st_r.pend && st_r.pend_val == i_wdata[bsc_pkg::BSC_CTRL_PDIS]) begin
            st_nxt.ctrl[bsc_pkg::BSC_CTRL_PDIS] = st_r.pend_val;            // [R6]
            st_nxt.pend = 1'b0;
         end else begin
            // First of a pair, or a mismatch that restarts the window   // [R6]
            st_nxt.pend     = 1'b1;
            st_nxt.pend_val = i_wdata[bsc_pkg::BSC_CTRL_PDIS];
            st_nxt.win      = 3'h0;
         end
      end
      if ((i_we && i_addr == bsc_pkg::BSC_OFS_STAT && !i_wdata[bsc_pkg::BSC_STAT_SRF])
          || i_por) begin
         st_nxt.stat[bsc_pkg::BSC_STAT_SRF] = 1'b0;                         // [R9]
      end
      // Set wins over a clear in the same cycle
      if (st_r.rst) begin
         st_nxt.stat[bsc_pkg::BSC_STAT_SRF] = 1'b1;                         // [R8]
      end

      // Enable kept in a flop so the status pin is registered
      st_nxt.en = st_nxt.sy2[bsc_pkg::BSC_SY_FUSE] & ~st_nxt.ctrl[bsc_pkg::BSC_CTRL_PDIS]; // [R5]

      // Register reads, answered the next cycle
      st_nxt.rdata = 8'h00;
      if (i_re) begin
         case (i_addr)
            bsc_pkg::BSC_OFS_CTRL: begin
               st_nxt.rdata = st_r.ctrl;
            end
            bsc_pkg::BSC_OFS_STAT: begin
               st_nxt.rdata = st_r.stat;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r      <= '0;
         st_r.ctrl <= bsc_pkg::BSC_CTRL_RST;
         st_r.stat <= bsc_pkg::BSC_STAT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign link.tdo                = st_r.tdo;
   assign o_rdata                 = st_r.rdata;
   // Reset follows the cell directly, no latch   // [R19]
   assign o_scan_reset            = st_r.rst;
   assign o_scan_reset_flag       = st_r.stat[bsc_pkg::BSC_STAT_SRF];
   assign o_scan_port_disable     = st_r.ctrl[bsc_pkg::BSC_CTRL_PDIS];
   assign o_global_pullup_disable = st_r.ctrl[bsc_pkg::BSC_CTRL_PUD];
   assign o_vector_table_select   = st_r.ctrl[bsc_pkg::BSC_CTRL_VECTOR_TABLE_SELECT];
   assign o_vector_change_enable  = st_r.ctrl[bsc_pkg::BSC_CTRL_VECTOR_CHANGE_ENABLE];
   assign o_scan_port_enabled     = st_r.en;
   assign o_chain_latch           = st_r.lat;

endmodule

`default_nettype wire

// >>> core/bsc_pkg.sv
package bsc_pkg;

   // ***************************************************************
   // Scan instruction codes
   // ***************************************************************
   localparam logic [3:0] BSC_IR_SAMPLE = 4'h2;
   localparam logic [3:0] BSC_IR_RESET  = 4'hC;
   localparam logic [3:0] BSC_IR_BYPASS = 4'hF;

   // ***************************************************************
   // Device register map, 8-bit data
   // ***************************************************************
   localparam logic [7:0] BSC_OFS_CTRL    = 8'h00;
   localparam logic [7:0] BSC_OFS_STAT    = 8'h01;
   localparam int         BSC_CTRL_PDIS   = 7;
   localparam int         BSC_CTRL_PUD    = 4;
   localparam int         BSC_CTRL_VECTOR_TABLE_SELECT  = 1;
   localparam int         BSC_CTRL_VECTOR_CHANGE_ENABLE   = 0;
   localparam logic [7:0] BSC_CTRL_PLAIN  = 8'h13;
   localparam logic [7:0] BSC_CTRL_RST    = 8'h00;
   localparam int         BSC_STAT_SRF    = 4;
   localparam logic [7:0] BSC_STAT_RST    = 8'h00;
   localparam int         BSC_WIN_CYC     = 4;

   // ***************************************************************
   // Link sampling: bit slots in the synchroniser vector
   // ***************************************************************
   localparam int BSC_SY_TCK  = 0;
   localparam int BSC_SY_TDI  = 1;
   localparam int BSC_SY_CAP  = 2;
   localparam int BSC_SY_SH   = 3;
   localparam int BSC_SY_UPD  = 4;
   localparam int BSC_SY_IR   = 5;
   localparam int BSC_SY_FUSE = 9;
   localparam int BSC_SY_W    = 10;

   // ***************************************************************
   // Chain layout
   // ***************************************************************
   localparam int BSC_PIN_CELLS = 3;
   localparam int BSC_NPIN_DEF  = 8;
   localparam int BSC_NOSC_DEF  = 3;

   // ***************************************************************
   // Controller register map, 32-bit data, byte addresses
   // ***************************************************************
   localparam logic [7:0] BSC_H_OFS_INSTR = 8'h00;
   localparam logic [7:0] BSC_H_OFS_LEN   = 8'h04;
   localparam logic [7:0] BSC_H_OFS_TX    = 8'h08;
   localparam logic [7:0] BSC_H_OFS_START = 8'h0C;
   localparam logic [7:0] BSC_H_OFS_STAT  = 8'h10;
   localparam logic [7:0] BSC_H_OFS_RX    = 8'h14;
   localparam int         BSC_H_HALF_DEF  = 8;

endpackage

// >>> core/bsc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bsc_link_if;
   logic       tck;
   logic       tdi;
   logic       tdo;
   logic       capture_dr;
   logic       shift_dr;
   logic       update_dr;
   logic [3:0] instr;

   // Test controller end
   modport ctl (output tck, output tdi, output capture_dr, output shift_dr,
                output update_dr, output instr, input tdo);
   // Scanned device end
   modport dev (input tck, input tdi, input capture_dr, input shift_dr,
                input update_dr, input instr, output tdo);
endinterface

`default_nettype wire

// >>> core/bsc_ctl.sv
`timescale 1ns/1ps
`default_nettype none

// Test controller: runs one capture, shift, update pass per start.
// It leaves clock choice in the chain to software.   [R18] [R7]
module bsc_ctl #(
   parameter int HALF = bsc_pkg::BSC_H_HALF_DEF
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Scan link
   bsc_link_if.ctl          link,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_we,
   input  wire logic        i_re,
   output logic      [31:0] o_rdata,
   // Status
   output logic             o_busy
);

   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

   typedef enum logic [1:0] {IDLE, CAPT, SHIFT, UPD} bsc_ctl_fsm_type;

   typedef struct packed {
      bsc_ctl_fsm_type fsm;
      logic [1:0]      sy;
      logic [7:0]      div;
      logic            tck;
      logic            tdi;
      logic            cap;
      logic            sh;
      logic            upd;
      logic [3:0]      instr;
      logic [5:0]      len;
      logic [5:0]      cnt;
      logic [31:0]     tx;
      logic [31:0]     txs;
      logic [31:0]     rx;
      logic [31:0]     rdata;
      logic            busy;
   } bsc_ctl_state_type;

   bsc_ctl_state_type st_r;
   bsc_ctl_state_type st_nxt;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      st_nxt    = st_r;
      st_nxt.sy = {st_r.sy[0], link.tdo};

      // Scan clock runs only while a pass is busy
      if (st_r.fsm != IDLE) begin
         st_nxt.div = st_r.div + 8'h01;
         if (st_r.div == HALF_LAST) begin
            st_nxt.div = 8'h00;
            st_nxt.tck = ~st_r.tck;
            if (!st_r.tck) begin
               if (st_r.fsm == SHIFT) begin
                  st_nxt.rx  = {st_r.sy[1], st_r.rx[31:1]};
                  st_nxt.cnt = st_r.cnt + 6'h01;
               end
            end else begin
               case (st_r.fsm)
                  CAPT: begin
                     st_nxt.cap = 1'b0;
                     if (st_r.len == 6'h00) begin
                        st_nxt.upd = 1'b1;
                        st_nxt.fsm = UPD;
                     end else begin
                        st_nxt.sh  = 1'b1;
                        st_nxt.tdi = st_r.txs[0];
                        st_nxt.txs = {1'b0, st_r.txs[31:1]};
                        st_nxt.fsm = SHIFT;
                     end
                  end
                  SHIFT: begin
                     if (st_r.cnt == st_r.len) begin
                        st_nxt.sh  = 1'b0;
                        st_nxt.upd = 1'b1;
                        st_nxt.fsm = UPD;
                     end else begin
                        st_nxt.tdi = st_r.txs[0];
                        st_nxt.txs = {1'b0, st_r.txs[31:1]};
                     end
                  end
                  UPD: begin
                     st_nxt.upd = 1'b0;
                     st_nxt.fsm = IDLE;
                  end
                  default: begin
                     st_nxt.fsm = IDLE;
                  end
               endcase
            end
         end
      end

      // Register writes; setup is ignored while busy
      if (i_we && st_r.fsm == IDLE) begin
         case (i_addr)
            bsc_pkg::BSC_H_OFS_INSTR: begin
               st_nxt.instr = i_wdata[3:0];
            end
            bsc_pkg::BSC_H_OFS_LEN: begin
               st_nxt.len = (i_wdata[5:0] > 6'd32) ? 6'd32 : i_wdata[5:0];
            end
            bsc_pkg::BSC_H_OFS_TX: begin
               st_nxt.tx = i_wdata;
            end
            bsc_pkg::BSC_H_OFS_START: begin
               st_nxt.fsm = CAPT;
               st_nxt.cap = 1'b1;
               st_nxt.txs = st_r.tx;
               st_nxt.rx  = 32'h0000_0000;
               st_nxt.cnt = 6'h00;
               st_nxt.div = 8'h00;
               st_nxt.tck = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // Busy kept in a flop so the status pin is registered
      st_nxt.busy = (st_nxt.fsm != IDLE);

      // Register reads, answered the next cycle
      st_nxt.rdata = 32'h0000_0000;
      if (i_re) begin
         case (i_addr)
            bsc_pkg::BSC_H_OFS_INSTR: st_nxt.rdata = {28'h0, st_r.instr};
            bsc_pkg::BSC_H_OFS_LEN:   st_nxt.rdata = {26'h0, st_r.len};
            bsc_pkg::BSC_H_OFS_TX:    st_nxt.rdata = st_r.tx;
            bsc_pkg::BSC_H_OFS_STAT:  st_nxt.rdata = {31'h0, (st_r.fsm != IDLE)};
            bsc_pkg::BSC_H_OFS_RX:    st_nxt.rdata = st_r.rx;
            default:                  st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r       <= '0;
         st_r.fsm   <= IDLE;
         st_r.instr <= bsc_pkg::BSC_IR_BYPASS;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign link.tck        = st_r.tck;
   assign link.tdi        = st_r.tdi;
   assign link.capture_dr = st_r.cap;
   assign link.shift_dr   = st_r.sh;
   assign link.update_dr  = st_r.upd;
   assign link.instr      = st_r.instr;
   assign o_rdata         = st_r.rdata;
   assign o_busy          = st_r.busy;

endmodule

`default_nettype wire

// >>> bench/bsc_link_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Scan link checker
// ****************************************
module bsc_link_properties (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   // Link signals
   input  wire logic       tck,
   input  wire logic       tdi,
   input  wire logic       tdo,
   input  wire logic       capture_dr,
   input  wire logic       shift_dr,
   input  wire logic       update_dr,
   input  wire logic [3:0] instr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Any scan state active
   wire act = capture_dr | shift_dr | update_dr;

   instr_held_pass_a: assert property (act |-> $stable(instr))
      else $error("instruction moved during a pass");
   tck_idle_low_a: assert property (!act |-> !tck)
      else $error("scan clock runs outside a pass");
   tck_half_period_a: assert property ($rose(tck) |-> tck[*8] ##1 !tck)
      else $error("scan clock high phase wrong");
   tdi_low_change_a: assert property ($changed(tdi) |-> !tck)
      else $error("serial input moved while clock high");
   tdo_low_change_a: assert property ($changed(tdo) |-> !tck)
      else $error("serial output moved while clock high");
   bypass_capture_zero_a: assert property (
      $rose(shift_dr) && instr == 4'hF |-> ##5 tdo == 1'b0)
      else $error("bypass capture not zero");
   bypass_shift_bit_a: assert property (
      $rose(tck) && shift_dr && instr == 4'hF |-> ##13 tdo == $past(tdi, 13))
      else $error("bypass cell lost serial bit");
   reset_shift_bit_a: assert property (
      $rose(tck) && shift_dr && instr == 4'hC |-> ##13 tdo == $past(tdi, 13))
      else $error("reset cell lost serial bit");
endmodule

`default_nettype wire

// >>> bench/boundary_scan_chain_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_chain_control_test;
   typedef struct packed {
      logic [3:0]  ins;
      logic [5:0]  len;
      logic [31:0] tx;
      logic [31:0] st;
   } bsc_row_type;

   logic        i_clk = 1'b0;
   logic        i_nrst;
   logic [7:0]  addr;
   logic [31:0] wdata, c_rdata, stim, rx, d, e, m, latch;
   logic [7:0]  d_rdata;
   logic        c_we, c_re, d_we, d_re, fuse, por;
   logic        sp_dis, pud_o, sp_en, srst, sflag;
   int          failures, n_checks, cyc;
   bsc_row_type rows [5] = '{'{4'hF, 6'd8, 32'hA5, 32'h0}, '{4'hF, 6'd1, 32'h1, 32'h0},
      '{4'h5, 6'd12, 32'hABC, 32'h0}, '{4'h2, 6'd32, 32'h12345678, 32'h5A3C96F0},
      '{4'h2, 6'd32, 32'hC0FFEE01, 32'hA5C3690F}};

   // ****************************************
   // Ends, link and checker
   // ****************************************
   always #12.5 i_clk = ~i_clk;
   bsc_link_if link ();
   bsc_ctl bsc_ctl_inst (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .i_addr(addr),
      .i_wdata(wdata), .i_we(c_we), .i_re(c_re), .o_rdata(c_rdata), .o_busy());
   bsc_dev bsc_dev_inst (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .i_addr(addr),
      .i_wdata(wdata[7:0]), .i_we(d_we), .i_re(d_re), .o_rdata(d_rdata),
      .i_scan_port_fuse(fuse), .i_por(por), .i_port_output_bit(stim[7:0]),
      .i_pin_direction_bit(stim[15:8]), .i_pin_level(stim[23:16]),
      .i_normal_reset_n(stim[24]), .i_high_voltage_reset(stim[25]),
      .i_osc_enable(stim[28:26]), .i_osc_clock(stim[31:29]), .o_scan_port_disable(sp_dis),
      .o_global_pullup_disable(pud_o), .o_vector_table_select(), .o_vector_change_enable(),
      .o_scan_port_enabled(sp_en), .o_scan_reset(srst), .o_scan_reset_flag(sflag),
      .o_chain_latch(latch));
   bsc_link_properties bsc_link_properties_inst (.i_clk(i_clk), .i_nrst(i_nrst),
      .tck(link.tck), .tdi(link.tdi), .tdo(link.tdo), .capture_dr(link.capture_dr),
      .shift_dr(link.shift_dr), .update_dr(link.update_dr), .instr(link.instr));

   // Expected chain image; pin data raw, no sync
   function automatic logic [31:0] chain(input logic [31:0] s, input logic p);
      logic [31:0] c;
      for (int i = 0; i < 8; i++) begin
         c[3*i]   = ~p & ~s[8+i] & s[i];
         c[3*i+1] = s[8+i];
         c[3*i+2] = s[16+i];
      end
      c[25:24] = s[25:24];
      for (int k = 0; k < 3; k++) begin
         c[26+2*k] = s[26+k];
         c[27+2*k] = s[29+k];
      end
      return c;
   endfunction

   // One-cycle strobes; c picks the controller, else the device
   task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      c_we <= c;
      d_we <= ~c;
      addr <= a;
      wdata <= v;
      @(posedge i_clk);
      c_we <= 1'b0;
      d_we <= 1'b0;
   endtask

   task automatic rd(input logic c, input logic [7:0] a);
      @(posedge i_clk);
      c_re <= c;
      d_re <= ~c;
      addr <= a;
      @(posedge i_clk);
      c_re <= 1'b0;
      d_re <= 1'b0;
      @(negedge i_clk);
      d = c ? c_rdata : {24'h0, d_rdata};
   endtask

   // One capture, shift, update pass; bounded wait on busy
   task automatic scan(input logic [3:0] ins, input logic [5:0] len, input logic [31:0] tx);
      wr(1'b1, bsc_pkg::BSC_H_OFS_INSTR, {28'h0, ins});
      wr(1'b1, bsc_pkg::BSC_H_OFS_LEN, {26'h0, len});
      wr(1'b1, bsc_pkg::BSC_H_OFS_TX, tx);
      wr(1'b1, bsc_pkg::BSC_H_OFS_START, 32'h1);
      for (int k = 0; k < 1000; k++) begin
         rd(1'b1, bsc_pkg::BSC_H_OFS_STAT);
         if (d[0] === 1'b0) break;
         if (k == 999) failures++;
      end
      rd(1'b1, bsc_pkg::BSC_H_OFS_RX);
      rx = d;
   endtask

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
         failures++;
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Hang guard, ceiling well above the planned run
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      {i_nrst, addr, wdata, c_we, c_re, d_we, d_re, stim, por} = '0;
      fuse = 1'b1;
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd(1'b0, bsc_pkg::BSC_OFS_CTRL);
      chk("ctrl reset", 32'h0, d);
      for (int i = 0; i < 5; i++) begin
         stim <= rows[i].st;
         scan(rows[i].ins, rows[i].len, rows[i].tx);
         e = (rows[i].ins == 4'h2) ? chain(rows[i].st, 1'b0) : {rows[i].tx[30:0], 1'b0};
         m = 32'hFFFFFFFF >> (32 - rows[i].len);
         chk("scan out", e & m, rx >> (32 - rows[i].len));
         if (rows[i].ins == 4'h2)
            chk("latch", rows[i].tx, latch);
      end
      // Plain bits take one write; global pull-up off masks cells
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'hFF);
      rd(1'b0, bsc_pkg::BSC_OFS_CTRL);
      chk("ctrl plain", 32'h13, d);
      chk("pud pin", 32'h1, {31'h0, pud_o});
      stim <= 32'h00FF00FF;
      scan(4'h2, 6'd32, 32'h0);
      chk("pullup off", chain(32'h00FF00FF, 1'b1), rx);
      // Pair at the window edge disables the port
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'h0);
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'h80);
      repeat (2) @(posedge i_clk);
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'h80);
      repeat (3) @(negedge i_clk);
      chk("disabled", 32'h2, {30'h0, sp_dis, sp_en});
      scan(4'h2, 6'd32, 32'hFFFF);
      chk("rx off", 32'h0, rx);
      // Late second write only restarts the window
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'h0);
      repeat (3) @(posedge i_clk);
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'h0);
      repeat (3) @(negedge i_clk);
      chk("late pair", 32'h1, {31'h0, sp_dis});
      wr(1'b0, bsc_pkg::BSC_OFS_CTRL, 32'h0);
      repeat (3) @(negedge i_clk);
      chk("enabled", 32'h1, {31'h0, sp_en});
      fuse <= 1'b0;
      repeat (4) @(negedge i_clk);
      chk("fuse off", 32'h0, {31'h0, sp_en});
      fuse <= 1'b1;
      repeat (3) @(posedge i_clk);
      // Reset cell: unlatched request, sticky flag
      scan(4'hC, 6'd1, 32'h1);
      chk("scan reset", 32'h3, {30'h0, srst, sflag});
      rd(1'b0, bsc_pkg::BSC_OFS_STAT);
      chk("flag set", 32'h10, d);
      scan(4'hC, 6'd1, 32'h0);
      chk("reset off", 32'h1, {30'h0, srst, sflag});
      wr(1'b0, bsc_pkg::BSC_OFS_STAT, 32'h0);
      rd(1'b0, bsc_pkg::BSC_OFS_STAT);
      chk("flag clear", 32'h0, d);
      scan(4'hC, 6'd1, 32'h1);
      scan(4'hC, 6'd1, 32'h0);
      por <= 1'b1;
      @(posedge i_clk);
      por <= 1'b0;
      rd(1'b0, bsc_pkg::BSC_OFS_STAT);
      chk("por clear", 32'h0, d);
      rd(1'b0, 8'h05);
      chk("unmapped", 32'h0, d);
      report_and_stop();
   end
endmodule

`default_nettype wire
